//--- core/cat_addr_xlate.v
// Processor I/O bus address decode, delay translation, command helper and configuration store.
`timescale 1ns/1ps
`include "cat_regs.vh"

module cat_addr_xlate (
  input  wire                    mclk_i,        // Slow divided PHY clock
  input  wire                    reset_i,       // Asynchronous reset, active high
  input  wire                    io_as_i,       // Processor address strobe
  input  wire                    io_rd_i,       // Processor read strobe
  input  wire                    io_wr_i,       // Processor write strobe
  input  wire [`CAT_IO_AW-1:0]   io_addr_i,     // Processor byte address
  input  wire [`CAT_IO_DW-1:0]   io_wdata_i,    // Processor write data
  output reg  [`CAT_IO_DW-1:0]   io_rdata_o,    // Processor read data
  output reg                     io_ready_o,    // Processor access done
  output reg  [`CAT_RIU_AW-1:0]  riu_addr_o,    // Shared nibble register address
  output reg  [`CAT_RIU_DW-1:0]  riu_wdata_o,   // Shared nibble register write data
  output reg                     riu_wr_en_o,   // Nibble register write strobe
  output reg  [`CAT_NIB_N-1:0]   riu_nib_sel_o, // One-hot nibble select
  input  wire [`CAT_RIU_DW-1:0]  riu_rdata_i,   // Selected nibble read data
  input  wire [7:0]              mc_cmd_i,      // Controller command
  input  wire                    mc_cmd_vld_i,  // Controller command valid
  output reg  [7:0]              phy_cmd_o,     // Command to PHY
  output reg                     phy_cmd_vld_o, // Command to PHY valid
  input  wire [15:0]             phy_rdata_i,   // PHY read data
  input  wire                    phy_rvld_i,    // PHY read data valid
  output reg                     init_done_o,   // Power-up initialization done
  output reg                     cal_done_o     // Calibration done, controller owns PHY while the OWN bit is clear
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function hit;
    input [`CAT_IO_AW-1:0] a;
    input [`CAT_IO_AW-1:0] base;
    input [`CAT_IO_AW-1:0] mask;
    begin
      hit = ((a & mask) == base);
    end
  endfunction

  function [`CAT_NIB_N-1:0] onehot;
    input [`CAT_NIB_W-1:0] n;
    begin
      onehot = {{(`CAT_NIB_N-1){1'b0}}, 1'b1} << n;
    end
  endfunction

  // --------------------------------------------------------------------------
  // Delay address translation
  // --------------------------------------------------------------------------
  wire [7:0]             dly_ofs = io_addr_i[7:0];
  wire                   dly_in  = (dly_ofs >= `CAT_DLY_IDLY_OFS);
  wire [5:0]             lbit    = dly_in ? dly_ofs[5:0] : dly_ofs[5:0];
  wire [`CAT_NIB_W-1:0]  map_nib;
  wire [2:0]             map_slc;

  cat_pin_map u_map (
    .lbit_i   (lbit),
    .nibble_o (map_nib),
    .slice_o  (map_slc)
  );

  // Output delays start at 0x0B, input delays at 0x12.
  wire [`CAT_RIU_AW-1:0] xl_addr = (dly_in ? `CAT_RIU_IDLY0 : `CAT_RIU_ODLY0) + {3'h0, map_slc};

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  wire sel_loc = hit(io_addr_i, `CAT_IO_LOCAL_BASE, `CAT_IO_LOCAL_MASK);
  // Only the first 32 offsets of the output and input ranges decode; the rest reads as unmapped.
  wire sel_dly = hit(io_addr_i, `CAT_IO_DLY_BASE, `CAT_IO_DLY_MASK) && !dly_ofs[7] && !dly_ofs[5];
  wire sel_cfg = hit(io_addr_i, `CAT_IO_CFG_BASE, `CAT_IO_CFG_MASK);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg [2:0]  ctrl_q;
  reg [7:0]  cmd_q;
  reg [15:0] rep_q;
  reg [15:0] rep_cnt_q;
  reg [15:0] exp_q;
  reg [15:0] mism_q;
  reg [15:0] rdcnt_q;
  reg        busy_q;
  reg [31:0] cfg_mem [0:`CAT_CFG_WORDS-1];
  reg        riu_pend_q;
  reg [1:0]  riu_wait_q;
  reg [13:0] init_cnt_q;

  localparam ST_INIT = 2'h0;
  localparam ST_CAL  = 2'h1;
  localparam ST_RUN  = 2'h2;
  reg [1:0] st_q;

  wire rd_acc = io_as_i & io_rd_i;
  wire wr_acc = io_as_i & io_wr_i;

  // --------------------------------------------------------------------------
  // Power-up sequencing
  // --------------------------------------------------------------------------
  // The wait is counted in hardware so memory init never depends on processor firmware.
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      st_q        <= ST_INIT;
      init_cnt_q  <= 14'h0000;
      init_done_o <= 1'b0;
      cal_done_o  <= 1'b0;
    end else begin
      case (st_q)
        ST_INIT: begin
          if (init_cnt_q == `CAT_INIT_CYC - 1) begin
            st_q        <= ST_CAL;
            init_done_o <= 1'b1;
          end else begin
            init_cnt_q <= init_cnt_q + 14'h0001;
          end
        end
        ST_CAL: begin
          if (ctrl_q[`CAT_CTRL_DONE_BIT]) begin
            st_q       <= ST_RUN;
            cal_done_o <= 1'b1;
          end
        end
        ST_RUN:  st_q <= ST_RUN;
        default: st_q <= ST_INIT;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Processor bus and nibble register port
  // --------------------------------------------------------------------------
  integer i;
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      io_rdata_o    <= 32'h00000000;
      io_ready_o    <= 1'b0;
      riu_addr_o    <= 6'h00;
      riu_wdata_o   <= 16'h0000;
      riu_wr_en_o   <= 1'b0;
      riu_nib_sel_o <= 8'h00;
      riu_pend_q    <= 1'b0;
      riu_wait_q    <= 2'h0;
      ctrl_q        <= `CAT_CTRL_RST;
      cmd_q         <= 8'h00;
      rep_q         <= 16'h0000;
      exp_q         <= 16'h0000;
      for (i = 0; i < `CAT_CFG_WORDS; i = i + 1) begin
        cfg_mem[i] <= 32'h00000000;
      end
    end else begin
      io_ready_o  <= 1'b0;
      riu_wr_en_o <= 1'b0;
      ctrl_q[`CAT_CTRL_GO_BIT] <= 1'b0;
      if (riu_pend_q) begin
        // Nibble read data is valid two cycles after the select is driven.
        if (riu_wait_q == 2'h1) begin
          io_rdata_o    <= {16'h0000, riu_rdata_i};
          io_ready_o    <= 1'b1;
          riu_pend_q    <= 1'b0;
          riu_nib_sel_o <= 8'h00;
        end
        riu_wait_q <= riu_wait_q + 2'h1;
      end else if (rd_acc | wr_acc) begin
        if (sel_dly) begin
          riu_addr_o    <= xl_addr;
          riu_nib_sel_o <= onehot(map_nib);
          riu_wdata_o   <= io_wdata_i[15:0];
          riu_wr_en_o   <= wr_acc;
          io_ready_o    <= wr_acc;
          riu_pend_q    <= rd_acc;
          riu_wait_q    <= 2'h0;
        end else begin
          io_ready_o <= 1'b1;
          io_rdata_o <= 32'h00000000;
          if (sel_cfg) begin
            if (wr_acc) begin
              cfg_mem[io_addr_i[5:2]] <= io_wdata_i;
            end
            io_rdata_o <= cfg_mem[io_addr_i[5:2]];
          end else if (sel_loc) begin
            case (dly_ofs)
              `CAT_REG_CTRL: begin
                if (wr_acc) ctrl_q <= io_wdata_i[2:0];
                io_rdata_o <= {29'h0, ctrl_q};
              end
              `CAT_REG_STATUS: io_rdata_o <= {29'h0, |mism_q, busy_q, init_done_o};
              `CAT_REG_CMD: begin
                if (wr_acc) cmd_q <= io_wdata_i[7:0];
                io_rdata_o <= {24'h0, cmd_q};
              end
              `CAT_REG_REPEAT: begin
                if (wr_acc) rep_q <= io_wdata_i[15:0];
                io_rdata_o <= {16'h0, rep_q};
              end
              `CAT_REG_EXPECT: begin
                if (wr_acc) exp_q <= io_wdata_i[15:0];
                io_rdata_o <= {16'h0, exp_q};
              end
              `CAT_REG_MISMATCH: io_rdata_o <= {16'h0, mism_q};
              `CAT_REG_RDCOUNT:  io_rdata_o <= {16'h0, rdcnt_q};
              default:           io_rdata_o <= 32'h00000000;
            endcase
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Command helper
  // --------------------------------------------------------------------------
  // Issuing from hardware gives one command per clock, which bus writes cannot reach.
  wire go    = ctrl_q[`CAT_CTRL_GO_BIT];
  wire start = go && !busy_q;
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_q        <= 1'b0;
      rep_cnt_q     <= 16'h0000;
      mism_q        <= 16'h0000;
      rdcnt_q       <= 16'h0000;
      phy_cmd_o     <= 8'h00;
      phy_cmd_vld_o <= 1'b0;
    end else begin
      if (go && !busy_q) begin
        busy_q    <= 1'b1;
        rep_cnt_q <= rep_q;
        mism_q    <= 16'h0000;
        rdcnt_q   <= 16'h0000;
      end else if (busy_q) begin
        if (rep_cnt_q == 16'h0000) begin
          busy_q <= 1'b0;
        end else begin
          rep_cnt_q <= rep_cnt_q - 16'h0001;
        end
      end
      // A read-back landing on the start cycle counts against the new run, not the old one.
      if (phy_rvld_i) begin
        rdcnt_q <= (start ? 16'h0000 : rdcnt_q) + 16'h0001;
        mism_q  <= (start ? 16'h0000 : mism_q) | (phy_rdata_i ^ exp_q);
      end
      // Calibration owns the PHY until it hands over.
      if (!ctrl_q[`CAT_CTRL_OWN_BIT] && cal_done_o) begin
        phy_cmd_o     <= mc_cmd_i;
        phy_cmd_vld_o <= mc_cmd_vld_i;
      end else begin
        phy_cmd_o     <= cmd_q;
        phy_cmd_vld_o <= busy_q;
      end
    end
  end

endmodule // cat_addr_xlate

//--- include/cat_regs.vh
// Address map, field positions and timing constants of the calibration address translator.
`ifndef CAT_REGS_VH
`define CAT_REGS_VH

// ----------------------------------------------------------------------------
// Processor I/O bus address map
// ----------------------------------------------------------------------------
`define CAT_IO_AW            28
`define CAT_IO_DW            32
`define CAT_IO_LOCAL_BASE    28'h0000000
`define CAT_IO_LOCAL_MASK    28'hfffff00
`define CAT_IO_DLY_BASE      28'h0004100
`define CAT_IO_DLY_MASK      28'hfffff00
`define CAT_IO_CFG_BASE      28'h0002000
`define CAT_IO_CFG_MASK      28'hfffffc0

// Local register word offsets (low byte of address).
`define CAT_REG_CTRL         8'h00
`define CAT_REG_STATUS       8'h04
`define CAT_REG_CMD          8'h08
`define CAT_REG_REPEAT       8'h0c
`define CAT_REG_EXPECT       8'h10
`define CAT_REG_MISMATCH     8'h14
`define CAT_REG_RDCOUNT      8'h18

// Control register fields.
`define CAT_CTRL_OWN_BIT     0
`define CAT_CTRL_DONE_BIT    1
`define CAT_CTRL_GO_BIT      2
`define CAT_CTRL_RST         3'h0

// Status register fields.
`define CAT_STAT_INIT_BIT    0
`define CAT_STAT_BUSY_BIT    1
`define CAT_STAT_MISM_BIT    2

// ----------------------------------------------------------------------------
// Nibble register space
// ----------------------------------------------------------------------------
`define CAT_RIU_AW           6
`define CAT_RIU_DW           16
`define CAT_NIB_N            8
`define CAT_NIB_W            3
`define CAT_RIU_ODLY0        6'h0b
`define CAT_RIU_IDLY0        6'h12
`define CAT_SLICE_N          7

// Logical delay offsets inside the delay window.
`define CAT_DLY_IDLY_OFS     8'h40

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CAT_CLK_MHZ          20
`define CAT_INIT_WAIT_US     200
`define CAT_INIT_CYC         (`CAT_INIT_WAIT_US * `CAT_CLK_MHZ)
`define CAT_CFG_WORDS        16

`endif

//--- core/cat_pin_map.v
// Fixed logical-to-physical delay element mapping for the chosen pinout.
`timescale 1ns/1ps
`include "cat_regs.vh"

module cat_pin_map (
  input  wire [5:0]              lbit_i,    // Logical data bit index
  output reg  [`CAT_NIB_W-1:0]   nibble_o,  // Physical nibble index
  output reg  [2:0]              slice_o    // Bit slice within the nibble
);

  // --------------------------------------------------------------------------
  // Pinout table
  // --------------------------------------------------------------------------
  // Placement is frozen when the pinout is chosen; logical bit 0 lands on slice 2 of nibble 6.
  always @* begin
    case (lbit_i[1:0])
      2'h0: slice_o = 3'h2;
      2'h1: slice_o = 3'h3;
      2'h2: slice_o = 3'h4;
      default: slice_o = 3'h5;
    endcase
    nibble_o = lbit_i[4:2] + 3'h6;
  end

endmodule // cat_pin_map

//--- tb/cat_addr_xlate_props.sv
// Port-level assertions of the calibration address translator.
`timescale 1ns/1ps
`include "cat_regs.vh"

module cat_addr_xlate_props (
  input wire logic        mclk_i,        // Clock
  input wire logic        reset_i,       // Reset
  input wire logic        io_as_i,       // Address strobe
  input wire logic        io_rd_i,       // Read strobe
  input wire logic        io_wr_i,       // Write strobe
  input wire logic [27:0] io_addr_i,     // Address
  input wire logic [31:0] io_wdata_i,    // Write data
  input wire logic [31:0] io_rdata_o,    // Read data
  input wire logic        io_ready_o,    // Done
  input wire logic [5:0]  riu_addr_o,    // Nibble address
  input wire logic [15:0] riu_wdata_o,   // Nibble data
  input wire logic        riu_wr_en_o,   // Nibble write
  input wire logic [7:0]  riu_nib_sel_o, // Nibble select
  input wire logic [15:0] riu_rdata_i,   // Nibble read data
  input wire logic        init_done_o    // Init done
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  logic        pend_q;
  logic [27:0] a_q;
  logic [15:0] w_q;
  logic [15:0] cnt_q;
  wire req = io_as_i && (io_rd_i || io_wr_i);
  wire tk  = req && !pend_q;
  wire dw  = (io_addr_i & `CAT_IO_DLY_MASK) == `CAT_IO_DLY_BASE && !io_addr_i[7] && !io_addr_i[5];
  wire unm = io_addr_i[27:8] != 20'h0 && !dw && (io_addr_i & `CAT_IO_CFG_MASK) != `CAT_IO_CFG_BASE;

  // Pending delay read tracking: the design refuses requests meanwhile.
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      pend_q <= 1'b0;
      a_q    <= 28'h0;
      w_q    <= 16'h0;
      cnt_q  <= 16'h0;
    end else begin
      pend_q <= (tk && io_rd_i && dw) ? 1'b1 : (io_ready_o ? 1'b0 : pend_q);
      a_q    <= tk ? io_addr_i : a_q;
      w_q    <= tk ? io_wdata_i[15:0] : w_q;
      cnt_q  <= (cnt_q == 16'd5000) ? cnt_q : cnt_q + 16'd1;
    end
  end

  a_ready_next: assert property (tk && !(io_rd_i && dw) |=> io_ready_o)
    else $error("access not answered next cycle");
  a_dly_read_lat: assert property (tk && io_rd_i && dw |=> ##1 !io_ready_o ##1 io_ready_o)
    else $error("delay read latency wrong");
  a_rd_data_mux: assert property (pend_q && io_ready_o |-> io_rdata_o == {16'h0, $past(riu_rdata_i)})
    else $error("delay read data not returned");
  a_bit0_map: assert property (tk && io_wr_i && io_addr_i == 28'h0004100 |=>
    riu_wr_en_o && riu_addr_o == 6'h0d && riu_nib_sel_o == 8'h40)
    else $error("bit 0 output delay mapped wrongly");
  a_slice_addr: assert property (tk && io_wr_i && dw && !io_addr_i[5] |=>
    riu_addr_o == (a_q[6] ? 6'h12 : 6'h0b) + 6'd2 + {4'h0, a_q[1:0]} && riu_wdata_o == w_q)
    else $error("slice address or data wrong");
  a_sel_onehot: assert property (riu_wr_en_o |-> $onehot(riu_nib_sel_o))
    else $error("nibble select not one-hot");
  a_unmapped_quiet: assert property (tk && unm |=> io_ready_o && !riu_wr_en_o)
    else $error("unmapped access misbehaved");
  a_unmapped_zero: assert property (tk && io_rd_i && unm |=> io_rdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_init_early: assert property (cnt_q < 16'd4000 |-> !init_done_o)
    else $error("init done too early");
  a_init_late: assert property (cnt_q == 16'd4000 |-> init_done_o)
    else $error("init done too late");
  a_init_held: assert property (init_done_o |=> init_done_o)
    else $error("init done dropped");
endmodule // cat_addr_xlate_props

//--- tb/cat_cpu_model.sv
// Processor I/O bus master model.
`timescale 1ns/1ps

module cat_cpu_model (
  input  wire logic        clk_i,   // Bus clock
  input  wire logic        ready_i, // Access done
  input  wire logic [31:0] rdata_i, // Read data
  output logic             as_o,    // Address strobe
  output logic             rd_o,    // Read strobe
  output logic             wr_o,    // Write strobe
  output logic [27:0]      addr_o,  // Address
  output logic [31:0]      wdata_o  // Write data
);
  int tmo = 0;

  initial begin
    as_o = 1'b0;
    rd_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 28'h0;
    wdata_o = 32'h0;
  end

  // Strobe for one cycle only, or a fast access would be taken twice.
  task automatic xfer(input logic w, input logic [27:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(negedge clk_i);
    as_o = 1'b1;
    rd_o = !w;
    wr_o = w;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    as_o = 1'b0;
    rd_o = 1'b0;
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
    while (ready_i !== 1'b1 && n < 8) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 8) tmo++;
    q = rdata_i;
  endtask
endmodule // cat_cpu_model

//--- tb/cat_addr_xlate_test.sv
// Self-checking bench of the calibration address translator.
`timescale 1ns/1ps
`include "cat_regs.vh"

module cat_addr_xlate_test;
  logic        mclk_i = 0, reset_i = 1, mc_cmd_vld_i = 0, phy_rvld_i = 0, pv = 0;
  logic [7:0]  mc_cmd_i = 0, cq;
  logic [15:0] phy_rdata_i = 0, ex;
  logic [31:0] rs = 32'h687c498d, acc = 0, d, q;
  logic [31:0] cfg[16];
  logic [63:0] m, ioq[$];
  logic [29:0] riuq[$];
  logic [7:0]  phyq[$];
  logic [27:0] a;
  logic [5:0]  ra;
  logic [2:0]  nb;
  int          err_count = 0, cmp_count = 0, phase = 0, nphy = 0, gap = 0, i, n;
  wire         io_as_i, io_rd_i, io_wr_i, io_ready_o, riu_wr_en_o, phy_cmd_vld_o, init_done_o, cal_done_o;
  wire [27:0]  io_addr_i;
  wire [31:0]  io_wdata_i, io_rdata_o;
  wire [5:0]   riu_addr_o;
  wire [15:0]  riu_wdata_o, riu_rdata_i;
  wire [7:0]   riu_nib_sel_o, phy_cmd_o;

  initial forever #25 mclk_i = ~mclk_i;
  // A deselected nibble port leaves a changing pattern, never the last value.
  assign riu_rdata_i = riu_nib_sel_o != 8'h00 ? {riu_nib_sel_o, 2'b01, riu_addr_o} : rs[15:0];

  cat_addr_xlate dut (.mclk_i, .reset_i, .io_as_i, .io_rd_i, .io_wr_i, .io_addr_i, .io_wdata_i, .io_rdata_o,
    .io_ready_o, .riu_addr_o, .riu_wdata_o, .riu_wr_en_o, .riu_nib_sel_o, .riu_rdata_i, .mc_cmd_i, .mc_cmd_vld_i,
    .phy_cmd_o, .phy_cmd_vld_o, .phy_rdata_i, .phy_rvld_i, .init_done_o, .cal_done_o);
  cat_cpu_model cpu (.clk_i(mclk_i), .ready_i(io_ready_o), .rdata_i(io_rdata_o), .as_o(io_as_i), .rd_o(io_rd_i),
    .wr_o(io_wr_i), .addr_o(io_addr_i), .wdata_o(io_wdata_i));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic io(input logic w, input logic [27:0] ad, input logic [31:0] dt, input logic [31:0] mk,
                    input logic [31:0] ev);
    ioq.push_back({mk, ev});
    cpu.xfer(w, ad, dt, q);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Output monitor and PHY side responder
  // ---------------------------------------------------------------------------
  always @(negedge mclk_i) begin
    if (io_ready_o === 1'b1) begin
      m = ioq.size() != 0 ? ioq.pop_front() : {32'h0, 32'h1};
      chk((io_rdata_o & m[63:32]) === m[31:0], "read data");
    end
    if (riu_wr_en_o === 1'b1) begin
      m[29:0] = riuq.size() != 0 ? riuq.pop_front() : 30'h3fffffff;
      chk({riu_addr_o, riu_nib_sel_o, riu_wdata_o} === m[29:0], "nibble write");
    end
    if (phy_cmd_vld_o === 1'b1) begin
      if (phase == 1) begin
        nphy++;
        gap += (nphy > 1 && !pv);
        chk(phy_cmd_o === cq, "helper command");
      end else chk(phyq.size() != 0 && phy_cmd_o === phyq.pop_front(), "passed command");
    end
    pv <= phy_cmd_vld_o === 1'b1;
    if (phy_rvld_i && phase == 1) acc <= acc | {16'h0, phy_rdata_i ^ ex};
    phy_rvld_i <= phy_cmd_vld_o === 1'b1;
    phy_rdata_i <= rs[31:16];
    mc_cmd_vld_i <= phase != 3 && rs[0];
    mc_cmd_i <= rs[15:8];
    if (phase == 2 && rs[0]) phyq.push_back(rs[15:8]);
    rs <= xs(rs);
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i);
    reset_i = 0;
    chk(io_ready_o === 1'b0 && riu_wr_en_o === 1'b0 && cal_done_o === 1'b0, "reset values");
    $display("test reset done");
    for (i = 0; i < 64; i++) begin
      a = `CAT_IO_DLY_BASE + (i[5] ? 28'h40 : 28'h0) + {23'h0, i[4:0]};
      nb = i[4:2] + 3'd6;
      ra = (i[5] ? `CAT_RIU_IDLY0 : `CAT_RIU_ODLY0) + 6'd2 + {4'h0, i[1:0]};
      d = rs;
      riuq.push_back({ra, 8'h01 << nb, d[15:0]});
      io(1'b1, a, d, 32'h0, 32'h0);
      io(1'b0, a, 32'h0, 32'hffffffff, {16'h0, 8'h01 << nb, 2'b01, ra});
    end
    $display("test delay map done");
    io(1'b0, 28'h0008000, 32'h0, 32'hffffffff, 32'h0);
    io(1'b1, 28'h0008000, rs, 32'h0, 32'h0);
    io(1'b0, 28'h0004120, 32'h0, 32'hffffffff, 32'h0);
    io(1'b0, 28'h0004180, 32'h0, 32'hffffffff, 32'h0);
    io(1'b1, 28'h0004190, rs, 32'h0, 32'h0);
    $display("test unmapped done");
    for (i = 0; i < 16; i++) begin
      cfg[i] = rs;
      io(1'b1, `CAT_IO_CFG_BASE + 28'(4 * i), cfg[i], 32'h0, 32'h0);
    end
    for (i = 0; i < 16; i++) io(1'b0, `CAT_IO_CFG_BASE + 28'(4 * i), 32'h0, 32'hffffffff, cfg[i]);
    $display("test config store done");
    n = 0;
    while (init_done_o !== 1'b1 && n < 5000) begin
      @(negedge mclk_i);
      n++;
    end
    chk(init_done_o === 1'b1, "init done");
    io(1'b0, {20'h0, `CAT_REG_STATUS}, 32'h0, 32'h7, 32'h1);
    $display("test init done");
    cq = rs[7:0];
    ex = rs[31:16];
    io(1'b1, {20'h0, `CAT_REG_CMD}, {24'h0, cq}, 32'h0, 32'h0);
    io(1'b1, {20'h0, `CAT_REG_REPEAT}, 32'h2, 32'h0, 32'h0);
    io(1'b1, {20'h0, `CAT_REG_EXPECT}, {16'h0, ex}, 32'h0, 32'h0);
    acc = 0;
    phase = 1;
    io(1'b1, {20'h0, `CAT_REG_CTRL}, 32'h5, 32'h0, 32'h0);
    repeat (40) @(negedge mclk_i);
    chk(nphy == 3 && gap == 0, "repeat burst");
    io(1'b0, {20'h0, `CAT_REG_MISMATCH}, 32'h0, 32'hffffffff, acc);
    io(1'b0, {20'h0, `CAT_REG_RDCOUNT}, 32'h0, 32'hffffffff, 32'h3);
    io(1'b0, {20'h0, `CAT_REG_STATUS}, 32'h0, 32'h4, {29'h0, acc != 0, 2'b00});
    $display("test helper done");
    phase = 3;
    io(1'b1, {20'h0, `CAT_REG_CTRL}, 32'h2, 32'h0, 32'h0);
    n = 0;
    while (cal_done_o !== 1'b1 && n < 8) begin
      @(negedge mclk_i);
      n++;
    end
    chk(cal_done_o === 1'b1, "handover");
    phase = 2;
    repeat (40) @(negedge mclk_i);
    phase = 3;
    repeat (6) @(negedge mclk_i);
    chk(phyq.size() == 0 && riuq.size() == 0 && ioq.size() == 0 && cpu.tmo == 0, "command flow");
    $display("test handover done");
    final_report();
  end

  initial begin
    #1000000;
    err_count++;
    final_report();
  end
endmodule // cat_addr_xlate_test

bind cat_addr_xlate cat_addr_xlate_props u_props (.mclk_i, .reset_i, .io_as_i, .io_rd_i, .io_wr_i, .io_addr_i,
  .io_wdata_i, .io_rdata_o, .io_ready_o, .riu_addr_o, .riu_wdata_o, .riu_wr_en_o, .riu_nib_sel_o, .riu_rdata_i,
  .init_done_o);
